// [common/mac_learn_pkg.sv]
//------------------------------------------------------------
// mac learning table constants
//------------------------------------------------------------
// Purpose: sizes, timing counts and states of the address table
// Assumes: 40 MHz system clock
// Notes:   aging uses a coarse epoch stamp per entry
package mac_learn_pkg;
  localparam int          TABLE_DEPTH  = 1024;
  localparam int          ADDR_W       = 10;
  localparam int          MAC_W        = 48;
  localparam int          PORT_W       = 2;
  localparam int          STAMP_W      = 4;
  localparam logic [9:0]  LAST_ENTRY   = 10'h3ff;
  localparam logic [3:0]  STAMP_RST    = 4'h0;
  // aging: period split into sweep steps, entry dies after more than that many steps
  localparam int          CLK_HZ       = 40_000_000;
  localparam int          AGE_PERIOD_S = 200;
  localparam logic [3:0]  AGE_STEPS    = 4'h8;
  localparam int          SWEEP_S      = AGE_PERIOD_S / int'(AGE_STEPS);
  localparam int          SWEEP_CYCLES = SWEEP_S * CLK_HZ;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LEARN = 3'h1,
    ST_WRITE = 3'h3,
    ST_LOOK  = 3'h2,
    ST_AGE   = 3'h6
  } state_t;

  // steps elapsed since the stamp, modulo the stamp width
  function automatic logic age_expired(input logic [3:0] epoch, input logic [3:0] stamp);
    logic [3:0] diff;
    diff = epoch - stamp;
    return diff > AGE_STEPS;
  endfunction : age_expired
endpackage : mac_learn_pkg

// [hdl/sweep_divider.sv]
//------------------------------------------------------------
// sweep tick divider
//------------------------------------------------------------
// Purpose: one-cycle enable pulse every PERIOD clocks
// Assumes: single clock domain
// Notes:   counter holds while disabled so aging time freezes
`timescale 1ns/100ps
module sweep_divider #(
  parameter int unsigned PERIOD = 1000
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // control
  input  wire logic i_en,
  // tick
  output logic      o_tick
);
  localparam int CNT_W = $clog2(PERIOD + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PERIOD - 1);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             next_tick;

  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (i_en) begin
      if (cnt == CNT_LAST) begin
        next_cnt  = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt    <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      o_tick <= next_tick;
    end
  end
endmodule : sweep_divider

// [hdl/mac_learn_table.sv]
//------------------------------------------------------------
// mac address learning table
//------------------------------------------------------------
// Purpose: learning, migration, aging and da lookup of unicast addresses
// Assumes: requests synchronous to i_clk, one engine for all ports
// Notes:   linear scan, up to 1025 cycles per request
// Operation
// - table holds 1024 entries, scanned linearly so any address can take any free entry
// - new entry only for a good frame whose source address is absent
// - new entry stores source address, ingress port and time stamp
// - table full: last entry is overwritten by the new address
// - good frame with known address on another port rewrites the port
// - every frame with a known source address refreshes the stamp
// - aging runs continuously, removing entries idle about 200 seconds
// - aging enable input stops both the clock of aging and removal
// - destination lookup returns hit and port of the dynamic entry
`timescale 1ns/100ps
module mac_learn_table
  import mac_learn_pkg::*;
#(
  parameter int unsigned SWEEP_CYCLES_P = SWEEP_CYCLES
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // source learning from the receive paths
  input  wire logic              i_learn_valid,
  input  wire logic [MAC_W-1:0]  i_learn_sa,
  input  wire logic [PORT_W-1:0] i_learn_port,
  input  wire logic              i_learn_good,
  // destination lookup from forwarding
  input  wire logic              i_look_valid,
  input  wire logic [MAC_W-1:0]  i_look_da,
  // configuration
  input  wire logic              i_aging_en,
  // status and answers
  output logic                   o_ready,
  output logic                   o_learn_done,
  output logic                   o_look_done,
  output logic                   o_look_hit,
  output logic [PORT_W-1:0]      o_look_port
);
  //------------------------------------------------------------
  // storage
  //------------------------------------------------------------
  logic [MAC_W-1:0]   ent_mac   [TABLE_DEPTH];
  logic [PORT_W-1:0]  ent_port  [TABLE_DEPTH];
  logic [STAMP_W-1:0] ent_stamp [TABLE_DEPTH];
  logic [TABLE_DEPTH-1:0] ent_valid;

  //------------------------------------------------------------
  // engine state
  //------------------------------------------------------------
  state_t              state,      next_state;
  logic [ADDR_W-1:0]   idx,        next_idx;
  logic [MAC_W-1:0]    key,        next_key;
  logic [PORT_W-1:0]   src_port,   next_src_port;
  logic                good,       next_good;
  logic                hit,        next_hit;
  logic [ADDR_W-1:0]   hit_idx,    next_hit_idx;
  logic                free_found, next_free_found;
  logic [ADDR_W-1:0]   free_idx,   next_free_idx;
  logic [STAMP_W-1:0]  epoch,      next_epoch;
  logic                sweep_pend, next_sweep_pend;
  logic                next_ready, next_learn_done, next_look_done, next_look_hit;
  logic [PORT_W-1:0]   next_look_port;
  // table write controls
  logic                wr_en, wr_port_en, kill_en;
  logic [ADDR_W-1:0]   wr_idx;
  logic                sweep_tick, match;
  logic [ADDR_W:0]     look_wait,  next_look_wait;

  sweep_divider #(
    .PERIOD (SWEEP_CYCLES_P)
  ) u_sweep (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_en   (i_aging_en),
    .o_tick (sweep_tick)
  );

  assign match = ent_valid[idx] && (ent_mac[idx] == key);

  always_comb begin
    next_state      = state;
    next_idx        = idx;
    next_key        = key;
    next_src_port   = src_port;
    next_good       = good;
    next_hit        = hit;
    next_hit_idx    = hit_idx;
    next_free_found = free_found;
    next_free_idx   = free_idx;
    next_epoch      = epoch;
    next_sweep_pend = sweep_pend | sweep_tick;  // a tick in the start cycle is kept
    next_learn_done = 1'b0;
    next_look_done  = 1'b0;
    next_look_hit   = o_look_hit;
    next_look_port  = o_look_port;
    wr_en           = 1'b0;
    wr_port_en      = 1'b0;
    kill_en         = 1'b0;
    wr_idx          = hit ? hit_idx : (free_found ? free_idx : LAST_ENTRY);
    next_look_wait  = (state == ST_LOOK) ? look_wait + 1'b1 : '0;
    case (state)
      ST_IDLE: begin
        next_idx        = '0;
        next_hit        = 1'b0;
        next_free_found = 1'b0;
        if (i_learn_valid) begin
          next_key      = i_learn_sa;
          next_src_port = i_learn_port;
          next_good     = i_learn_good;
          next_state    = ST_LEARN;
        end else if (i_look_valid) begin
          next_key   = i_look_da;
          next_state = ST_LOOK;
        end else if (sweep_pend) begin
          next_sweep_pend = sweep_tick;
          next_epoch      = epoch + 1'b1;
          next_state      = ST_AGE;
        end
      end
      ST_LEARN: begin
        // deterministic linear scan instead of hashing, stopping at a match
        if (!ent_valid[idx] && !free_found) begin
          next_free_found = 1'b1;
          next_free_idx   = idx;
        end
        if (match) begin
          next_hit     = 1'b1;
          next_hit_idx = idx;
          next_state   = ST_WRITE;
        end else if (idx == LAST_ENTRY) begin
          next_state = good ? ST_WRITE : ST_IDLE;
          next_learn_done = !good;
        end else begin
          next_idx = idx + 1'b1;
        end
      end
      ST_WRITE: begin
        wr_en           = 1'b1;
        wr_port_en      = !hit || good;
        next_learn_done = 1'b1;
        next_state      = ST_IDLE;
      end
      ST_LOOK: begin
        if (match || idx == LAST_ENTRY) begin
          next_look_hit  = match;
          next_look_port = ent_port[idx];
          next_look_done = 1'b1;
          next_state     = ST_IDLE;
        end else begin
          next_idx = idx + 1'b1;
        end
      end
      ST_AGE: begin
        kill_en = i_aging_en && ent_valid[idx] && age_expired(epoch, ent_stamp[idx]);
        if (idx == LAST_ENTRY) begin
          next_state = ST_IDLE;
        end else begin
          next_idx = idx + 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_ready = (next_state == ST_IDLE);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state        <= ST_IDLE;
      idx          <= '0;
      key          <= '0;
      src_port     <= '0;
      good         <= 1'b0;
      hit          <= 1'b0;
      hit_idx      <= '0;
      free_found   <= 1'b0;
      free_idx     <= '0;
      epoch        <= STAMP_RST;
      sweep_pend   <= 1'b0;
      o_ready      <= 1'b0;
      o_learn_done <= 1'b0;
      o_look_done  <= 1'b0;
      o_look_hit   <= 1'b0;
      o_look_port  <= '0;
      look_wait    <= '0;
    end else begin
      state        <= next_state;
      idx          <= next_idx;
      key          <= next_key;
      src_port     <= next_src_port;
      good         <= next_good;
      hit          <= next_hit;
      hit_idx      <= next_hit_idx;
      free_found   <= next_free_found;
      free_idx     <= next_free_idx;
      epoch        <= next_epoch;
      sweep_pend   <= next_sweep_pend;
      o_ready      <= next_ready;
      o_learn_done <= next_learn_done;
      o_look_done  <= next_look_done;
      o_look_hit   <= next_look_hit;
      o_look_port  <= next_look_port;
      look_wait    <= next_look_wait;
    end
  end

  //------------------------------------------------------------
  // table update
  //------------------------------------------------------------
  // only valid bits are reset; contents behind a clear bit are read only as the port of a lookup miss
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ent_valid <= '0;
    end else if (wr_en) begin
      ent_valid[wr_idx] <= 1'b1;
    end else if (kill_en) begin
      ent_valid[idx] <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (wr_en) begin
      ent_mac[wr_idx]   <= key;
      ent_stamp[wr_idx] <= epoch;
      if (wr_port_en) begin
        ent_port[wr_idx] <= src_port;
      end
    end
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  AST_NO_BAD_NEW: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_WRITE && !hit) |-> good)
    else $error("new entry created from a bad frame");

  AST_NEW_ENTRY_FIELDS: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_WRITE && !hit) |=> (ent_valid[$past(wr_idx)] && ent_mac[$past(wr_idx)] == $past(key)
      && ent_port[$past(wr_idx)] == $past(src_port) && ent_stamp[$past(wr_idx)] == $past(epoch)))
    else $error("new entry fields not stored");

  AST_FULL_REPLACES_LAST: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_WRITE && !hit && !free_found) |-> (wr_idx == LAST_ENTRY))
    else $error("full table did not replace last entry");

  AST_MIGRATE_PORT: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_WRITE && hit && good) |=> (ent_port[$past(hit_idx)] == $past(src_port)))
    else $error("station migration did not rewrite port");

  AST_REFRESH_STAMP: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_LEARN && match) |=> ##1 (ent_stamp[$past(idx, 2)] == epoch))
    else $error("known address stamp not refreshed");

  AST_AGE_ONLY_EXPIRED: assert property (@(posedge i_clk) disable iff (i_rst)
    kill_en |-> (state == ST_AGE && age_expired(epoch, ent_stamp[idx])))
    else $error("entry removed before its aging period");

  AST_AGING_OFF: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_aging_en |-> !kill_en)
    else $error("entry removed while aging disabled");

  AST_AGE_REMOVES: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_AGE && i_aging_en && ent_valid[idx] && age_expired(epoch, ent_stamp[idx])) |=> !ent_valid[$past(idx)])
    else $error("expired entry not removed");

  AST_AGE_KEEPS_FRESH: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_AGE && ent_valid[idx] && !age_expired(epoch, ent_stamp[idx])) |=> ent_valid[$past(idx)])
    else $error("fresh entry removed");

  AST_LOOK_BOUNDED: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_LOOK) |-> (int'(look_wait) < TABLE_DEPTH))
    else $error("lookup scan too long");

  AST_LOOK_DONE: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_LOOK && next_state == ST_IDLE) |=> o_look_done)
    else $error("lookup answer missing");

  AST_LOOK_PORT: assert property (@(posedge i_clk) disable iff (i_rst)
    (state == ST_LOOK && match) |=> (o_look_done && o_look_hit && o_look_port == $past(ent_port[idx])))
    else $error("lookup hit returned wrong port");
endmodule : mac_learn_table

// [tb/mac_side_model.sv]
//------------------------------------------------------------
// receive path and forwarding requester
//------------------------------------------------------------
// Purpose: far-side model issuing learn and lookup requests
// Assumes: one request at a time, driven at the falling edge
// Notes:   released address lines carry the inverse of the last value
`timescale 1ns/100ps
module mac_side_model
  import mac_learn_pkg::*;
(
  // clock
  input  wire logic              i_clk,
  // answers from the table
  input  wire logic              i_ready,
  input  wire logic              i_learn_done,
  input  wire logic              i_look_done,
  input  wire logic              i_look_hit,
  input  wire logic [PORT_W-1:0] i_look_port,
  // requests to the table
  output logic                   o_learn_valid,
  output logic [MAC_W-1:0]       o_learn_sa,
  output logic [PORT_W-1:0]      o_learn_port,
  output logic                   o_learn_good,
  output logic                   o_look_valid,
  output logic [MAC_W-1:0]       o_look_da
);
  int                lat;
  logic              seen_hit;
  logic [PORT_W-1:0] seen_port;
  logic              seen_ready;

  initial begin
    o_learn_valid = 1'b0;
    o_learn_sa    = 48'h0;
    o_learn_port  = 2'h0;
    o_learn_good  = 1'b0;
    o_look_valid  = 1'b0;
    o_look_da     = 48'h0;
  end

  // kind 1 learns, kind 0 looks up; lat counts cycles from the taking edge
  task automatic request(input logic kind, input logic [MAC_W-1:0] mac,
                         input logic [PORT_W-1:0] port, input logic good);
    int n;
    n = 0;
    @(negedge i_clk);
    if (kind) begin
      o_learn_sa    = mac;
      o_learn_port  = port;
      o_learn_good  = good;
      o_learn_valid = 1'b1;
    end else begin
      o_look_da    = mac;
      o_look_valid = 1'b1;
    end
    // hold everything until ready is seen high at a rising edge
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ready !== 1'b1 && n < 4000);
    @(negedge i_clk);
    o_learn_valid = 1'b0;
    o_look_valid  = 1'b0;
    o_learn_sa    = ~o_learn_sa;
    o_learn_port  = ~o_learn_port;
    o_learn_good  = ~o_learn_good;
    o_look_da     = ~o_look_da;
    lat = 1;
    while ((kind ? i_learn_done : i_look_done) !== 1'b1 && lat < 1100) begin
      @(negedge i_clk);
      lat++;
    end
    if (lat >= 1100 || n >= 4000) lat = -1;
    seen_hit   = i_look_hit;
    seen_port  = i_look_port;
    seen_ready = i_ready;
  endtask : request
endmodule : mac_side_model

// [tb/test_mac_learn_table.sv]
//------------------------------------------------------------
// learning table testbench
//------------------------------------------------------------
// Purpose: learning, migration, refresh, aging and lookup checks
// Assumes: short sweep period so aging fits in the run
// Notes:   full-table replacement needs a million cycles, left out
`timescale 1ns/100ps
module test_mac_learn_table
  import mac_learn_pkg::*;
;
  localparam int unsigned      SWEEP = 2000;
  localparam int               LIMIT = 90000;
  localparam logic [MAC_W-1:0] MAC_A = 48'h0200000000a1;
  localparam logic [MAC_W-1:0] MAC_B = 48'h0200000000b2;

  logic              i_clk      = 1'b0;
  logic              i_rst      = 1'b1;
  logic              i_aging_en = 1'b1;
  logic              learn_valid, learn_good, look_valid;
  logic [MAC_W-1:0]  learn_sa, look_da;
  logic [PORT_W-1:0] learn_port, look_port;
  logic              ready, learn_done, look_done, look_hit;
  int                mismatches = 0;
  int                n_compared = 0;
  int                cycles     = 0;

  always #12.5 i_clk = ~i_clk;

  mac_learn_table #(.SWEEP_CYCLES_P(SWEEP)) i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_learn_valid(learn_valid), .i_learn_sa(learn_sa),
    .i_learn_port(learn_port), .i_learn_good(learn_good), .i_look_valid(look_valid),
    .i_look_da(look_da), .i_aging_en(i_aging_en), .o_ready(ready), .o_learn_done(learn_done),
    .o_look_done(look_done), .o_look_hit(look_hit), .o_look_port(look_port));

  mac_side_model i_model (
    .i_clk(i_clk), .i_ready(ready), .i_learn_done(learn_done), .i_look_done(look_done),
    .i_look_hit(look_hit), .i_look_port(look_port), .o_learn_valid(learn_valid),
    .o_learn_sa(learn_sa), .o_learn_port(learn_port), .o_learn_good(learn_good),
    .o_look_valid(look_valid), .o_look_da(look_da));

  task automatic test_done();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // a hang is cut short here
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      test_done();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  // exp_lat of zero skips the latency compare (scan position not fixed)
  task automatic learn(input logic [MAC_W-1:0] mac, input logic [PORT_W-1:0] port,
                       input logic good, input int exp_lat);
    i_model.request(1'b1, mac, port, good);
    if (exp_lat > 0) check("learn latency", 32'(exp_lat), 32'(i_model.lat));
    else check("learn done", 32'h1, 32'(i_model.lat > 0));
    check("ready with learn done", 32'h1, {31'h0, i_model.seen_ready});
  endtask : learn

  // a miss scans all entries, so its latency is fixed
  task automatic look(input logic [MAC_W-1:0] mac, input logic hit, input logic [PORT_W-1:0] port);
    i_model.request(1'b0, mac, 2'h0, 1'b0);
    check("lookup hit", {31'h0, hit}, {31'h0, i_model.seen_hit});
    if (hit) check("lookup port", {30'h0, port}, {30'h0, i_model.seen_port});
    if (hit) check("lookup done", 32'h1, 32'(i_model.lat > 0));
    else check("miss latency", 32'd1025, 32'(i_model.lat));
    check("ready with lookup done", 32'h1, {31'h0, i_model.seen_ready});
  endtask : look

  task automatic wait_cycles(input int n);
    repeat (n) @(negedge i_clk);
  endtask : wait_cycles

  task automatic test_learning();
    look(MAC_A, 1'b0, 2'h0);
    learn(MAC_A, 2'h1, 1'b0, 1025);
    look(MAC_A, 1'b0, 2'h0);
    learn(MAC_A, 2'h1, 1'b1, 1026);
    look(MAC_A, 1'b1, 2'h1);
    learn(MAC_B, 2'h3, 1'b1, 1026);
    look(MAC_B, 1'b1, 2'h3);
    look(MAC_A, 1'b1, 2'h1);
  endtask : test_learning

  task automatic test_migration();
    learn(MAC_A, 2'h2, 1'b1, 0);
    look(MAC_A, 1'b1, 2'h2);
    learn(MAC_A, 2'h0, 1'b0, 0);
    look(MAC_A, 1'b1, 2'h2);
  endtask : test_migration

  // nine sweeps of at least SWEEP cycles remove an idle entry
  task automatic test_aging();
    learn(MAC_A, 2'h2, 1'b1, 0);
    learn(MAC_B, 2'h3, 1'b1, 0);
    // short enough that at most eight sweeps pass before the refresh
    wait_cycles(14000);
    learn(MAC_A, 2'h1, 1'b0, 0);
    @(negedge i_clk);
    i_aging_en = 1'b0;
    wait_cycles(8000);
    @(negedge i_clk);
    i_aging_en = 1'b1;
    wait_cycles(12000);
    look(MAC_A, 1'b1, 2'h2);
    look(MAC_B, 1'b0, 2'h0);
    wait_cycles(17000);
    look(MAC_A, 1'b0, 2'h0);
  endtask : test_aging

  initial begin
    wait_cycles(5);
    check("ready in reset", 32'h0, {31'h0, ready});
    i_rst = 1'b0;
    @(negedge i_clk);
    check("ready after reset", 32'h1, {31'h0, ready});
    test_learning();
    test_migration();
    test_aging();
    test_done();
  end
endmodule : test_mac_learn_table
